// file: verilog/urp_pkg.sv
// shared constants and types for the serial receive path and its far-end transmitter
package urp_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int WORD_W = 9;
	localparam int DEPTH = 4;
	localparam int ENTRY_W = WORD_W + 2;
	localparam int BAUD_W = 16;
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_MODE = 5'h04;
	localparam logic [4:0] OFS_BAUD = 5'h08;
	localparam logic [4:0] OFS_RXDATA = 5'h0c;
	localparam int ST_AVAIL = 0;
	localparam int ST_OVR = 1;
	localparam int ST_RX_PARITY_ERROR = 2;
	localparam int ST_RX_FRAMING_ERROR = 3;
	localparam int ST_ISEL_LO = 6;
	localparam int MD_NINE = 0;
	localparam int MD_PAR_LO = 1;
	localparam int MD_ABAUD = 5;
	localparam int MD_WAKE = 7;
	localparam int MD_SIDL = 13;
	localparam int MD_EN = 15;
	localparam int EN_RX_PARITY_ERROR = 9;
	localparam int EN_RX_FRAMING_ERROR = 10;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] ISEL_THREE = 2'h2;
	localparam logic [1:0] ISEL_FULL = 2'h3;
	localparam logic [2:0] CNT_THREE = 3'h3;
	localparam logic [2:0] CNT_FULL = 3'h4;
	localparam logic [3:0] SUB_MID = 4'h7;
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] BITS_SHORT = 4'h7;
	localparam logic [3:0] BITS_LONG = 4'h8;
	localparam logic [3:0] FRAME_SHORT = 4'h9;
	localparam logic [3:0] FRAME_LONG = 4'ha;
	localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;
	typedef enum logic [1:0] {
		URP_IDLE  = 2'b00,
		URP_START = 2'b01,
		URP_DATA  = 2'b11,
		URP_STOP  = 2'b10
	} urp_state_e;
endpackage

// file: verilog/urp_if.sv
// serial line between the far transmitter and the receive path
`timescale 1ns/1ps
interface urp_if;
	logic rx_line;
	modport dev (input rx_line);
	modport far (output rx_line);
endinterface

// file: verilog/urp_rx.sv
// receive path: line sampler, four-word queue, status and mode registers on ahb-lite
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module urp_rx (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       ce,
	urp_if.dev                              link,
	input  wire logic                       hsel,
	input  wire logic [urp_pkg::ADDR_W-1:0] haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [urp_pkg::DATA_W-1:0] hwdata,
	input  wire logic                       hready,
	output logic      [urp_pkg::DATA_W-1:0] hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	input  wire logic                       sleep_mode,
	input  wire logic                       idle_mode,
	output logic                            rx_irq_pulse,
	output logic                            capture_in
);
	import urp_pkg::*;

	typedef struct packed {
		logic                         sync1;
		logic                         sync2;
		logic                         prev;
		urp_state_e                   st;
		logic [BAUD_W-1:0]            tick;
		logic [3:0]                   sub;
		logic [3:0]                   bitn;
		logic [WORD_W-1:0]            shift;
		logic                         pend;
		logic [ENTRY_W-1:0]           pend_w;
		logic [DEPTH-1:0][ENTRY_W-1:0] mem;
		logic [1:0]                   rd;
		logic [2:0]                   cnt;
		logic [ENTRY_W-1:0]           last;
		logic [1:0]                   isel;
		logic                         ovr;
		logic                         en;
		logic                         sidl;
		logic                         wake;
		logic                         abaud;
		logic                         nine;
		logic [1:0]                   par;
		logic [BAUD_W-1:0]            baud;
		logic                         wr_pend;
		logic [4:0]                   wr_addr;
		logic                         irq;
		logic [DATA_W-1:0]            rdata;
	} urp_rx_s;

	urp_rx_s s_r;
	urp_rx_s s_nxt;

	logic                acc;
	logic                fall;
	logic                tick_hit;
	logic                run;
	logic                push;
	logic                pop;
	logic                stop_done;
	logic [ENTRY_W-1:0]  word;
	logic [ENTRY_W-1:0]  push_w;
	logic [2:0]          cnt_free;
	logic [2:0]          cnt_new;
	logic [3:0]          nlast;

	// top of queue, or the last word handed out once the queue has drained
	function automatic logic [ENTRY_W-1:0] top_word(input urp_rx_s s);
		top_word = (s.cnt != 3'h0) ? s.mem[s.rd] : s.last;
	endfunction

	function automatic logic [DATA_W-1:0] read_mux(input urp_rx_s s, input logic [4:0] a);
		logic [ENTRY_W-1:0] t;
		t = top_word(s);
		read_mux = '0;
		unique case (a)
			OFS_STATUS: begin
				read_mux[ST_AVAIL] = (s.cnt != 3'h0);
				read_mux[ST_OVR] = s.ovr;
				read_mux[ST_RX_PARITY_ERROR] = t[EN_RX_PARITY_ERROR];
				read_mux[ST_RX_FRAMING_ERROR] = t[EN_RX_FRAMING_ERROR];
				read_mux[ST_ISEL_LO+1:ST_ISEL_LO] = s.isel;
			end
			OFS_MODE: begin
				read_mux[MD_NINE] = s.nine;
				read_mux[MD_PAR_LO+1:MD_PAR_LO] = s.par;
				read_mux[MD_ABAUD] = s.abaud;
				read_mux[MD_WAKE] = s.wake;
				read_mux[MD_SIDL] = s.sidl;
				read_mux[MD_EN] = s.en;
			end
			OFS_BAUD: read_mux[BAUD_W-1:0] = s.baud;
			OFS_RXDATA: read_mux[WORD_W-1:0] = t[WORD_W-1:0];
			default: read_mux = '0;
		endcase
	endfunction

	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		stop_done = 1'b0;
		push_w = s_r.pend_w;
		word = '0;
		// synchroniser, then edge detect on the second stage only
		s_nxt.sync1 = link.rx_line;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		fall = s_r.prev & ~s_r.sync2;
		acc = hsel & htrans[1] & hready;
		tick_hit = (s_r.tick == s_r.baud);
		run = s_r.en & ~sleep_mode & ~(idle_mode & s_r.sidl);
		nlast = (s_r.nine | (s_r.par != PAR_NONE)) ? BITS_LONG : BITS_SHORT;

		// write data phase, applied one cycle after the address phase
		if (s_r.wr_pend) begin
			s_nxt.wr_pend = 1'b0;
			unique case (s_r.wr_addr)
				OFS_STATUS: begin
					s_nxt.isel = hwdata[ST_ISEL_LO+1:ST_ISEL_LO];
					if (!hwdata[ST_OVR])
						s_nxt.ovr = 1'b0;
				end
				OFS_MODE: begin
					s_nxt.nine = hwdata[MD_NINE];
					s_nxt.par = hwdata[MD_PAR_LO+1:MD_PAR_LO];
					s_nxt.abaud = hwdata[MD_ABAUD];
					s_nxt.wake = hwdata[MD_WAKE];
					s_nxt.sidl = hwdata[MD_SIDL];
					s_nxt.en = hwdata[MD_EN];
				end
				OFS_BAUD: s_nxt.baud = hwdata[BAUD_W-1:0];
				default: ;
			endcase
		end

		if (acc) begin
			if (hwrite) begin
				s_nxt.wr_pend = 1'b1;
				s_nxt.wr_addr = haddr[4:0];
			end else begin
				s_nxt.rdata = read_mux(s_r, haddr[4:0]);
				// an empty read leaves the queue as it is
				if (haddr[4:0] == OFS_RXDATA && s_r.cnt != 3'h0) begin
					pop = 1'b1;
					s_nxt.last = s_r.mem[s_r.rd];
				end
			end
		end

		// sleep aborts a frame but touches no register or queue entry
		if (sleep_mode | ~s_r.en) begin
			s_nxt.st = URP_IDLE;
		end else if (run) begin
			if (s_r.st == URP_IDLE) begin
				// no new frame while an overrun or a held character is outstanding
				if (fall & ~s_r.ovr & ~s_r.pend) begin
					s_nxt.st = URP_START;
					s_nxt.tick = '0;
					s_nxt.sub = '0;
				end
			end else begin
				s_nxt.tick = tick_hit ? '0 : BAUD_W'(s_r.tick + 16'h0001);
				if (tick_hit) begin
					s_nxt.sub = 4'(s_r.sub + 4'h1);
					if (s_r.sub == SUB_MID) begin
						unique case (s_r.st)
							URP_IDLE: ;
							URP_START: begin
								// a glitch that is high again at mid start is dropped
								if (s_r.sync2)
									s_nxt.st = URP_IDLE;
								else begin
									s_nxt.st = URP_DATA;
									s_nxt.bitn = '0;
								end
							end
							URP_DATA: begin
								s_nxt.shift[s_r.bitn] = s_r.sync2;
								if (s_r.bitn == nlast)
									s_nxt.st = URP_STOP;
								else
									s_nxt.bitn = 4'(s_r.bitn + 4'h1);
							end
							URP_STOP: begin
								s_nxt.st = URP_IDLE;
								stop_done = 1'b1;
							end
						endcase
					end
				end
			end
		end

		cnt_free = 3'(s_r.cnt - {2'b00, pop});
		word[EN_RX_FRAMING_ERROR] = ~s_r.sync2;
		word[EN_RX_PARITY_ERROR] = ~s_r.nine & (s_r.par != PAR_NONE) &
			((^s_r.shift) != (s_r.par == PAR_ODD));
		word[WORD_W-1:0] = s_r.nine ? s_r.shift : {1'b0, s_r.shift[WORD_W-2:0]};

		if (stop_done) begin
			if (cnt_free < CNT_FULL) begin
				push = 1'b1;
				push_w = word;
			end else begin
				s_nxt.ovr = 1'b1;
				s_nxt.pend = 1'b1;
				s_nxt.pend_w = word;
			end
		end else if (s_r.pend & ~s_r.ovr & (cnt_free < CNT_FULL)) begin
			push = 1'b1;
			s_nxt.pend = 1'b0;
		end

		if (push)
			s_nxt.mem[2'(s_r.rd + s_r.cnt[1:0])] = push_w;
		if (pop)
			s_nxt.rd = 2'(s_r.rd + 2'h1);
		cnt_new = 3'(cnt_free + {2'b00, push});
		s_nxt.cnt = cnt_new;

		if (push) begin
			unique case (s_r.isel)
				ISEL_THREE: s_nxt.irq = (cnt_new == CNT_THREE);
				ISEL_FULL: s_nxt.irq = (cnt_new == CNT_FULL);
				default: s_nxt.irq = 1'b1;
			endcase
		end
		if (sleep_mode & s_r.wake & s_r.en & fall)
			s_nxt.irq = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.sync1 <= 1'b1;
			s_r.sync2 <= 1'b1;
			s_r.prev <= 1'b1;
			s_r.st <= URP_IDLE;
			s_r.baud <= BAUD_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// one stall cycle per write keeps a following read from seeing stale data
	assign hreadyout = ce & ~s_r.wr_pend;
	assign hresp = 1'b0;
	assign hrdata = s_r.rdata;
	assign rx_irq_pulse = s_r.irq;
	assign capture_in = s_r.abaud ? s_r.sync2 : 1'b1;
endmodule

// file: verilog/urp_tx.sv
// far-end serial transmitter that drives the receive line
`timescale 1ns/1ps
module urp_tx (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        ce,
	urp_if.far                               link,
	input  wire logic [urp_pkg::WORD_W-1:0]  tx_data,
	input  wire logic                        tx_valid,
	output logic                             tx_ready,
	input  wire logic                        nine_bit,
	input  wire logic [1:0]                  parity_mode,
	input  wire logic [urp_pkg::BAUD_W-1:0]  baud_div
);
	import urp_pkg::*;

	typedef struct packed {
		logic [BAUD_W-1:0]  tick;
		logic [3:0]         sub;
		logic [3:0]         bitn;
		logic [3:0]         last;
		logic [ENTRY_W-1:0] frame;
		logic               busy;
		logic               line;
	} urp_tx_s;

	urp_tx_s s_r;
	urp_tx_s s_nxt;
	logic    pbit;

	always_comb begin
		s_nxt = s_r;
		pbit = (^tx_data[WORD_W-2:0]) ^ (parity_mode == PAR_ODD);
		if (!s_r.busy) begin
			if (tx_valid & tx_ready) begin
				s_nxt.busy = 1'b1;
				s_nxt.tick = '0;
				s_nxt.sub = '0;
				s_nxt.bitn = '0;
				s_nxt.line = 1'b0;
				if (nine_bit) begin
					s_nxt.frame = {1'b1, tx_data, 1'b0};
					s_nxt.last = FRAME_LONG;
				end else if (parity_mode != PAR_NONE) begin
					s_nxt.frame = {1'b1, pbit, tx_data[WORD_W-2:0], 1'b0};
					s_nxt.last = FRAME_LONG;
				end else begin
					s_nxt.frame = {2'b11, tx_data[WORD_W-2:0], 1'b0};
					s_nxt.last = FRAME_SHORT;
				end
			end
		end else begin
			s_nxt.tick = (s_r.tick == baud_div) ? '0 : BAUD_W'(s_r.tick + 16'h0001);
			if (s_r.tick == baud_div) begin
				s_nxt.sub = 4'(s_r.sub + 4'h1);
				if (s_r.sub == SUB_LAST) begin
					if (s_r.bitn == s_r.last) begin
						s_nxt.busy = 1'b0;
						s_nxt.line = 1'b1;
					end else begin
						s_nxt.bitn = 4'(s_r.bitn + 4'h1);
						s_nxt.line = s_r.frame[4'(s_r.bitn + 4'h1)];
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '0;
			s_r.line <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign tx_ready = ce & ~s_r.busy;
	assign link.rx_line = s_r.line;
endmodule

// file: testbench/urp_chk.sv
// serial line and bus handshake assertions for the receive path pair
`timescale 1ns/1ps
module urp_chk #(
	parameter int LOW_MAX = 320
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic rx_line,
	input wire logic hresp,
	input wire logic hreadyout,
	input wire logic rx_irq_pulse,
	input wire logic sleep_mode,
	input wire logic capture_in
);
	typedef struct packed {
		logic [9:0] low;
	} urp_chk_s;
	urp_chk_s st_r;
	urp_chk_s st_nxt;
	// longest legal low run is start plus nine zero bits
	always_comb begin
		st_nxt = st_r;
		st_nxt.low = rx_line ? 10'h000 : st_r.low + 10'h001;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("slave answered with an error response");
	a_wait_one: assert property (!hreadyout |=> hreadyout)
		else $error("more than one wait state");
	a_irq_single: assert property (rx_irq_pulse |=> !rx_irq_pulse)
		else $error("interrupt pulse longer than one cycle");
	// a wake pulse in sleep follows a falling edge, so only pushes are held to the stop bit
	a_irq_line_high: assert property (rx_irq_pulse && !sleep_mode |-> rx_line)
		else $error("word pushed while line is not in its stop bit");
	a_start_min: assert property ($fell(rx_line) |-> !rx_line [*8])
		else $error("start bit too short");
	a_low_bound: assert property (int'(st_r.low) <= LOW_MAX)
		else $error("line low longer than one frame");
	a_idle_after_reset: assert property ($rose(hresetn) |-> rx_line)
		else $error("line not idle high after reset");
	a_capture_sync: assert property (!capture_in |-> !$past(rx_line, 2) || !$past(rx_line, 3))
		else $error("capture output low without a low line");
	c_irq: cover property (rx_irq_pulse);
	c_start: cover property ($fell(rx_line));
	c_wait: cover property (!hreadyout);
endmodule

// file: testbench/tb_uart_receive_path.sv
// self-checking bench: transmitter end feeds the receive end over the serial line
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_uart_receive_path;
	import urp_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        tx_valid = 1'b0, nine = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0]  htrans = 2'h0, par = 2'h0;
	logic [8:0]  tx_data = '0, w;
	logic [15:0] baud = 16'h0001;
	logic        hreadyout, hresp, rx_irq_pulse, capture_in, tx_ready;
	logic [31:0] lfsr = 32'he99b732e;
	int          fails = 0, num_checks = 0, irqs = 0;
	logic [8:0]  q[$];
	urp_if urp_if_i ();
	urp_rx urp_rx_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(urp_if_i), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sleep_mode(sleep_mode), .idle_mode(idle_mode), .rx_irq_pulse(rx_irq_pulse),
		.capture_in(capture_in));
	urp_tx urp_tx_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(urp_if_i),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .nine_bit(nine),
		.parity_mode(par), .baud_div(baud));
	urp_chk #(.LOW_MAX(320)) urp_chk_i (.hclk(hclk), .hresetn(hresetn),
		.rx_line(urp_if_i.rx_line), .hresp(hresp), .hreadyout(hreadyout),
		.rx_irq_pulse(rx_irq_pulse), .sleep_mode(sleep_mode), .capture_in(capture_in));
	initial begin
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) if (rx_irq_pulse === 1'b1) irqs++;
	function automatic logic [8:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[8:0];
	endfunction
	// pulses expected when n = 4 words arrive into an empty queue
	function automatic int irq_exp(input logic [1:0] sel, input int n);
		return sel[1] ? 1 : n;
	endfunction
	task automatic wrap_up();
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// waits on the transmitter's ready when on_tx is set, else on the bus ready
	task automatic hold(input logic on_tx, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((on_tx ? tx_ready : hreadyout) !== 1'b1 && n < lim);
		if ((on_tx ? tx_ready : hreadyout) !== 1'b1) begin
			fails++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= wr;
		hold(1'b0, 100);
		htrans <= 2'h0;
		hwdata <= d;
		hold(1'b0, 100);
		r = hrdata;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, '0);
		`CHK(r, e)
	endtask
	task automatic send(input logic [8:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		hold(1'b1, 2000);
		tx_valid <= 1'b0;
		@(posedge hclk);
	endtask
	// the push lands mid stop bit, well before the transmitter frees up
	task automatic settle();
		hold(1'b1, 2000);
		repeat (4) @(posedge hclk);
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_STATUS, '0);
		rd(OFS_MODE, '0);
		rd(5'h10, '0);
		bus(1'b1, OFS_BAUD, {16'h0, baud});
		for (int s = 0; s < 4; s++) begin
			nine <= s[0];
			// even parity, then odd, each once without the ninth bit overriding it
			par <= {s[1], ~s[1]};
			bus(1'b1, OFS_MODE, {28'h802, 1'b0, s[1], ~s[1], s[0]});
			bus(1'b1, OFS_STATUS, {24'h0, s[1:0], 6'h00});
			irqs = 0;
			for (int i = 0; i < 4; i++) begin
				q.push_back(rnd() & {s[0], 8'hff});
				send(q[$]);
			end
			settle();
			`CHK(irqs, irq_exp(s[1:0], 4))
			rd(OFS_STATUS, {24'h0, s[1:0], 6'h01});
			for (int i = 0; i < 4; i++) begin
				w = q.pop_front();
				rd(OFS_RXDATA, {23'h0, w});
			end
		end
		rd(OFS_RXDATA, {23'h0, w});
		rd(OFS_STATUS, 32'hc0);
		bus(1'b1, OFS_STATUS, '0);
		for (int i = 0; i < 6; i++) begin
			q.push_back(rnd());
			send(q[$]);
		end
		settle();
		rd(OFS_STATUS, 32'h3);
		for (int i = 0; i < 4; i++) rd(OFS_RXDATA, {23'h0, q.pop_front()});
		bus(1'b1, OFS_STATUS, '0);
		repeat (4) @(posedge hclk);
		rd(OFS_RXDATA, {23'h0, q.pop_front()});
		rd(OFS_STATUS, '0);
		send(9'h1a5);
		send(9'h05a);
		repeat (60) @(posedge hclk);
		sleep_mode <= 1'b1;
		settle();
		sleep_mode <= 1'b0;
		rd(OFS_RXDATA, 32'h1a5);
		rd(OFS_STATUS, '0);
		rd(OFS_MODE, 32'h8025);
		bus(1'b1, OFS_MODE, 32'h80a5);
		irqs = 0;
		sleep_mode <= 1'b1;
		// all ones after the start bit: the start edge is the only falling edge
		send(9'h1ff);
		settle();
		sleep_mode <= 1'b0;
		`CHK(irqs, 1)
		rd(OFS_STATUS, '0);
		bus(1'b1, OFS_MODE, 32'ha025);
		idle_mode <= 1'b1;
		send(9'h0c3);
		settle();
		rd(OFS_STATUS, '0);
		bus(1'b1, OFS_MODE, 32'h8025);
		send(9'h13c);
		settle();
		idle_mode <= 1'b0;
		rd(OFS_RXDATA, 32'h13c);
		send(rnd());
		settle();
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_STATUS, '0);
		wrap_up();
	end
endmodule
